// File: rtl/smc_pkg.sv
// Constants and carrier types for the socket mode configuration block
package smc_pkg;

    // =========================================================
    // Register map
    localparam logic [11:0] SMC_MODE_OFS     = 12'h200;
    localparam logic [11:0] SMC_ACTIVE_OFS   = 12'h204;
    localparam logic [15:0] SMC_MODE_RESET   = 16'h0000;
    localparam logic [15:0] SMC_MODE_WMASK   = 16'h01ef;

    // =========================================================
    // Field positions in socket_mode
    localparam int SMC_STRIP_BIT  = 8;
    localparam int SMC_MCAST_BIT  = 7;
    localparam int SMC_FILT_BIT   = 6;
    localparam int SMC_NDACK_BIT  = 5;
    localparam int SMC_PROTO_LSB  = 0;
    localparam int SMC_PROTO_W    = 4;

    // =========================================================
    // Protocol codes
    localparam logic [3:0] SMC_PROTO_TCP = 4'h1;
    localparam logic [3:0] SMC_PROTO_UDP = 4'h2;
    localparam logic [3:0] SMC_PROTO_RAW = 4'h4;

    localparam logic [47:0] SMC_BCAST_MAC = 48'hffff_ffff_ffff;
    localparam logic [1:0]  SMC_RESP_OKAY = 2'h0;
    localparam logic [1:0]  SMC_RESP_ERR  = 2'h2;

    // =========================================================
    // Carriers
    typedef struct packed {
        logic [3:0] proto;
        logic       strip_active;
        logic       mcast_active;
        logic       filt_active;
        logic       ndack_active;
    } smc_mode_out_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        aw_taken;
        logic        w_taken;
        logic [11:0] aw_addr;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } smc_bus_t;

    typedef struct packed {
        smc_bus_t      bus;
        logic [15:0]   mode;
        smc_mode_out_t opt;
        logic          prepend_header;
        logic          frm_accept;
        logic          frm_accept_valid;
        logic          ack_send;
    } smc_state_t;

endpackage : smc_pkg

// File: rtl/smc_socket_mode.sv
// Socket mode register with AXI4-Lite access and protocol-qualified option decode
`timescale 1ns/1ps

module smc_socket_mode
    import smc_pkg::*;
#(
    parameter int ADDR_W = 12
)(
    // Clock and reset
    input  wire logic                sys_clk,
    input  wire logic                rst_b,
    // AXI4-Lite write address and data
    input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic [2:0]          s_axi_awprot,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    // AXI4-Lite read
    input  wire logic [ADDR_W-1:0]   s_axi_araddr,
    input  wire logic [2:0]          s_axi_arprot,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    // Mode seen by the protocol engines
    output smc_mode_out_t            mode_out,
    output logic                     prepend_header,
    // Raw frame filter
    input  wire logic                frm_valid,
    input  wire logic [47:0]         frm_dest_mac,
    input  wire logic [47:0]         own_mac,
    output logic                     frm_accept,
    output logic                     frm_accept_valid,
    // Acknowledge scheduling
    input  wire logic                rx_data_pkt,
    input  wire logic                rto_expired,
    output logic                     ack_send
);

    if (ADDR_W < 12 || ADDR_W > 32)
    begin : g_bad_addr
        $error("smc_socket_mode: ADDR_W must be 12..32");
    end

    smc_state_t st;
    smc_state_t next_st;

    // =========================================================
    // Next-state logic
    always_comb
    begin
        logic [11:0]   rd_addr;
        logic [15:0]   wr_val;
        logic [3:0]    proto;
        logic          is_tcp;
        rd_addr = s_axi_araddr[11:0];
        wr_val  = 16'h0000;
        proto   = 4'h0;
        is_tcp  = 1'b0;
        next_st = st;

        // Write channel: address and data in either order
        // A held address or data item blocks its own channel until the response is taken
        if (s_axi_awvalid && st.bus.awready)
        begin
            next_st.bus.aw_taken = 1'b1;
            next_st.bus.aw_addr  = s_axi_awaddr[11:0];
        end
        if (s_axi_wvalid && st.bus.wready)
        begin
            next_st.bus.w_taken = 1'b1;
            next_st.bus.w_data  = s_axi_wdata;
            next_st.bus.w_strb  = s_axi_wstrb;
        end
        if (st.bus.bvalid && s_axi_bready)
        begin
            next_st.bus.bvalid = 1'b0;
        end
        if (next_st.bus.aw_taken && next_st.bus.w_taken && !next_st.bus.bvalid)
        begin
            next_st.bus.aw_taken = 1'b0;
            next_st.bus.w_taken  = 1'b0;
            next_st.bus.bvalid   = 1'b1;
            next_st.bus.bresp    = SMC_RESP_OKAY;
            if (next_st.bus.aw_addr[11:2] == SMC_MODE_OFS[11:2])
            begin
                wr_val = st.mode;
                if (next_st.bus.w_strb[0])
                begin
                    wr_val[7:0] = next_st.bus.w_data[7:0];
                end
                if (next_st.bus.w_strb[1])
                begin
                    wr_val[15:8] = next_st.bus.w_data[15:8];
                end
                next_st.mode = wr_val & SMC_MODE_WMASK;
            end
            else if (next_st.bus.aw_addr[11:2] != SMC_ACTIVE_OFS[11:2])
            begin
                next_st.bus.bresp = SMC_RESP_ERR;
            end
        end
        next_st.bus.awready = !next_st.bus.aw_taken && !next_st.bus.bvalid;
        next_st.bus.wready  = !next_st.bus.w_taken && !next_st.bus.bvalid;

        // Read channel
        if (st.bus.rvalid && s_axi_rready)
        begin
            next_st.bus.rvalid = 1'b0;
        end
        if (s_axi_arvalid && st.bus.arready)
        begin
            next_st.bus.rvalid = 1'b1;
            next_st.bus.rresp  = SMC_RESP_OKAY;
            next_st.bus.rdata  = 32'h0000_0000;
            if (rd_addr[11:2] == SMC_MODE_OFS[11:2])
            begin
                next_st.bus.rdata = {16'h0000, st.mode};
            end
            else if (rd_addr[11:2] == SMC_ACTIVE_OFS[11:2])
            begin
                next_st.bus.rdata = {28'h0000000, st.opt.strip_active, st.opt.mcast_active,
                                     st.opt.filt_active, st.opt.ndack_active};
            end
            else
            begin
                next_st.bus.rresp = SMC_RESP_ERR;
            end
        end
        next_st.bus.arready = !next_st.bus.rvalid;

        // Protocol-qualified options follow the stored mode
        // An option outside its protocol reads as inactive, so engines need no mode check
        proto  = next_st.mode[SMC_PROTO_LSB +: SMC_PROTO_W];
        is_tcp = (proto == SMC_PROTO_TCP);
        next_st.opt.proto        = proto;
        next_st.opt.strip_active = next_st.mode[SMC_STRIP_BIT] && is_tcp;
        next_st.opt.mcast_active = next_st.mode[SMC_MCAST_BIT] && (proto == SMC_PROTO_UDP);
        next_st.opt.filt_active  = next_st.mode[SMC_FILT_BIT] && (proto == SMC_PROTO_RAW);
        next_st.opt.ndack_active = next_st.mode[SMC_NDACK_BIT] && is_tcp;
        next_st.prepend_header   = !next_st.opt.strip_active;

        // Frame filter verdict, one cycle after the frame is offered
        next_st.frm_accept_valid = frm_valid;
        next_st.frm_accept       = !st.opt.filt_active || (frm_dest_mac == own_mac)
                                   || (frm_dest_mac == SMC_BCAST_MAC);

        // Acknowledge trigger depends on the no-delay option
        // Outside TCP no acknowledge is ever scheduled
        if (st.opt.proto == SMC_PROTO_TCP)
        begin
            if (st.opt.ndack_active)
            begin
                next_st.ack_send = rx_data_pkt;
            end
            else
            begin
                next_st.ack_send = rto_expired;
            end
        end
        else
        begin
            next_st.ack_send = 1'b0;
        end
    end

    // =========================================================
    // State register
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            // Whole state clears; the size header stays on until strip is enabled in TCP mode
            st                <= '0;
            st.mode           <= SMC_MODE_RESET;
            st.prepend_header <= 1'b1;
        end
        else
        begin
            st <= next_st;
        end
    end

    // =========================================================
    // Outputs
    assign s_axi_awready    = st.bus.awready;
    assign s_axi_wready     = st.bus.wready;
    assign s_axi_bvalid     = st.bus.bvalid;
    assign s_axi_bresp      = st.bus.bresp;
    assign s_axi_arready    = st.bus.arready;
    assign s_axi_rvalid     = st.bus.rvalid;
    assign s_axi_rdata      = st.bus.rdata;
    assign s_axi_rresp      = st.bus.rresp;
    assign mode_out         = st.opt;
    assign prepend_header   = st.prepend_header;
    assign frm_accept       = st.frm_accept;
    assign frm_accept_valid = st.frm_accept_valid;
    assign ack_send         = st.ack_send;

endmodule : smc_socket_mode

// File: verif/smc_socket_mode_sva.sv
// Concurrent checks on the socket mode block ports
`timescale 1ns/1ps
module smc_socket_mode_sva
    import smc_pkg::*;
(
    // Clock and reset
    input  wire logic          sys_clk,
    input  wire logic          rst_b,
    // Decoded mode
    input  wire smc_mode_out_t mode_out,
    input  wire logic          prepend_header,
    // Frame filter
    input  wire logic          frm_valid,
    input  wire logic [47:0]   frm_dest_mac,
    input  wire logic [47:0]   own_mac,
    input  wire logic          frm_accept,
    input  wire logic          frm_accept_valid,
    // Acknowledge scheduling
    input  wire logic          rx_data_pkt,
    input  wire logic          rto_expired,
    input  wire logic          ack_send
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    // =========================================================
    // Sequences
    sequence s_pass;
        frm_valid && (!mode_out.filt_active || frm_dest_mac == own_mac || frm_dest_mac == SMC_BCAST_MAC);
    endsequence
    sequence s_drop;
        frm_valid && mode_out.filt_active && frm_dest_mac != own_mac && frm_dest_mac != SMC_BCAST_MAC;
    endsequence
    sequence s_tcp_late; mode_out.proto == SMC_PROTO_TCP && !mode_out.ndack_active; endsequence

    // =========================================================
    // Properties
    property p_strip; mode_out.strip_active |-> mode_out.proto == SMC_PROTO_TCP; endproperty
    property p_hdr; prepend_header != mode_out.strip_active; endproperty
    property p_mcast; mode_out.mcast_active |-> mode_out.proto == SMC_PROTO_UDP; endproperty
    property p_filt; mode_out.filt_active |-> mode_out.proto == SMC_PROTO_RAW; endproperty
    property p_pass; s_pass |=> frm_accept_valid && frm_accept; endproperty
    property p_drop; s_drop |=> frm_accept_valid && !frm_accept; endproperty
    property p_nd; mode_out.ndack_active && rx_data_pkt |=> ack_send; endproperty
    property p_rto; s_tcp_late ##0 rto_expired |=> ack_send; endproperty
    property p_late; s_tcp_late ##0 (rx_data_pkt && !rto_expired) |=> !ack_send; endproperty
    property p_quiet; mode_out.proto != SMC_PROTO_TCP |=> !ack_send; endproperty

    a_strip: assert property (p_strip) else $error("strip active outside TCP");
    a_hdr: assert property (p_hdr) else $error("size header not tied to strip");
    a_mcast: assert property (p_mcast) else $error("multicast active outside UDP");
    a_filt: assert property (p_filt) else $error("filter active outside raw mode");
    a_pass: assert property (p_pass) else $error("frame wrongly dropped");
    a_drop: assert property (p_drop) else $error("frame wrongly accepted");
    a_nd: assert property (p_nd) else $error("no immediate acknowledge");
    a_rto: assert property (p_rto) else $error("no acknowledge on timeout");
    a_late: assert property (p_late) else $error("early acknowledge");
    a_quiet: assert property (p_quiet) else $error("acknowledge outside TCP");
endmodule : smc_socket_mode_sva

bind smc_socket_mode smc_socket_mode_sva u_sva (
    .sys_clk, .rst_b, .mode_out, .prepend_header, .frm_valid, .frm_dest_mac, .own_mac,
    .frm_accept, .frm_accept_valid, .rx_data_pkt, .rto_expired, .ack_send
);

// File: verif/testbench.sv
// Self-checking bench for the socket mode block
`timescale 1ns/1ps
module testbench;
    import smc_pkg::*;
    logic          sys_clk = 0;
    logic          rst_b = 0;
    logic [11:0]   s_axi_awaddr = '0;
    logic [11:0]   s_axi_araddr = '0;
    logic [31:0]   s_axi_wdata = '0;
    logic          s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic          s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]    s_axi_bresp, s_axi_rresp, rr;
    logic [31:0]   s_axi_rdata, rd;
    logic          frm_valid = 0, rx_data_pkt = 0, rto_expired = 0;
    logic          frm_accept, frm_accept_valid, ack_send, prepend_header;
    logic [47:0]   frm_dest_mac = '0;
    logic [47:0]   own_mac = 48'h0200_0000_0a01;
    smc_mode_out_t mode_out;
    int            error_cnt = 0;
    int            samples_checked = 0;
    // Mode word, decoded byte, pulses {frame,data,timeout}, address pick, expected {valid,accept,ack}
    logic [31:0]   rows [16] = '{32'h0101_1800, 32'h0102_2000, 32'h0082_2400, 32'h0081_1000,
        32'h0044_4286, 32'h0044_428e, 32'h0044_4294, 32'h0041_1096, 32'h0004_4096, 32'h0021_1141,
        32'h0021_1120, 32'h0001_1021, 32'h0001_1040, 32'h0024_4060, 32'hfff1_1900, 32'h0000_0000};

    always #2.5 sys_clk = ~sys_clk;

    smc_socket_mode u_dut (
        .sys_clk, .rst_b, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb(4'h3), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .mode_out, .prepend_header, .frm_valid, .frm_dest_mac, .own_mac,
        .frm_accept, .frm_accept_valid, .rx_data_pkt, .rto_expired, .ack_send
    );

    // =========================================================
    // Tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
            error_cnt++;
        if (got !== exp)
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    endtask : chk

    task automatic summarize();
        if (error_cnt == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : summarize

    // One AXI4-Lite write (w=1) or read (w=0); response code lands in rr, read data in rd
    task automatic ax(input logic w, input logic [11:0] a, input logic [15:0] d);
        int   n = 0;
        logic ad = 0;
        logic wd = !w;
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= {16'h0, d};
        s_axi_awvalid <= w;
        s_axi_wvalid <= w;
        s_axi_arvalid <= !w;
        s_axi_bready <= w;
        s_axi_rready <= !w;
        do
        begin
            @(posedge sys_clk);
            n++;
            ad |= w ? s_axi_awready : s_axi_arready;
            wd |= s_axi_wready;
            if (ad) s_axi_awvalid <= 0;
            if (ad) s_axi_arvalid <= 0;
            if (wd) s_axi_wvalid <= 0;
        end
        while (!(ad && wd) && n < 64);
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (!(w ? s_axi_bvalid : s_axi_rvalid) && n < 64);
        s_axi_bready <= 0;
        s_axi_rready <= 0;
        rd = s_axi_rdata;
        rr = w ? s_axi_bresp : s_axi_rresp;
        if (n >= 64)
            error_cnt++;
        if (n >= 64)
            summarize();
    endtask : ax

    task automatic stim(input logic [2:0] s, input logic [47:0] m);
        @(posedge sys_clk);
        {frm_valid, rx_data_pkt, rto_expired} <= s;
        frm_dest_mac <= m;
        @(posedge sys_clk);
        {frm_valid, rx_data_pkt, rto_expired} <= 3'h0;
        #1;
    endtask : stim

    // =========================================================
    // Main sequence
    initial
    begin
        logic [31:0] r;
        repeat (5) @(posedge sys_clk);
        rst_b <= 1;
        #1;
        chk(32'(mode_out), 32'h0);
        chk(32'(prepend_header), 32'h1);
        foreach (rows[i])
        begin
            r = rows[i];
            ax(1, SMC_MODE_OFS, r[31:16]);
            chk(32'(rr), 32'(SMC_RESP_OKAY));
            chk(32'(mode_out), 32'(r[15:8]));
            chk(32'(prepend_header), 32'(!r[11]));
            ax(0, SMC_MODE_OFS, 16'h0);
            chk(rd, 32'(r[31:16] & 16'h01ef));
            stim(r[7:5], r[4] ? ~own_mac : (r[3] ? SMC_BCAST_MAC : own_mac));
            chk(32'({frm_accept_valid, frm_accept & r[7], ack_send}), 32'(r[2:0]));
        end
        ax(1, 12'h208, 16'h0101);
        chk(32'(rr), 32'(SMC_RESP_ERR));
        chk(32'(mode_out), 32'h0);
        ax(0, 12'h208, 16'h0);
        chk(32'(rr), 32'(SMC_RESP_ERR));
        ax(1, SMC_MODE_OFS, 16'h0101);
        ax(0, SMC_ACTIVE_OFS, 16'h0);
        chk(rd, 32'h8);
        ax(1, SMC_ACTIVE_OFS, 16'h0);
        chk(32'(rr), 32'(SMC_RESP_OKAY));
        chk(32'(mode_out), 32'h18);
        rst_b <= 0;
        repeat (2) @(posedge sys_clk);
        rst_b <= 1;
        #1;
        chk(32'(prepend_header), 32'h1);
        chk(32'(mode_out), 32'h0);
        ax(0, SMC_MODE_OFS, 16'h0);
        chk(rd, 32'h0);
        summarize();
    end
endmodule : testbench
